// *** logic/fpc_defines.vh ***
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
// ==========================================
// operation control word
`define FPC_KEY 16'hA442
`define FPC_KEY_HI 31
`define FPC_KEY_LO 16
`define FPC_OP_WRITE 0
`define FPC_OP_ERASE 1
`define FPC_OP_MASS_ERASE_BIT 2
`define FPC_OP_COMMIT 3
// ==========================================
// commit selectors on the target address
`define FPC_SEL_READ0 2'h0
`define FPC_SEL_PROG0 2'h1
`define FPC_SEL_READ1 2'h2
`define FPC_SEL_PROG1 2'h3
// ==========================================
// reset values
`define FPC_USEC_RESET 8'h31
`define FPC_PROT_RESET 32'hFFFFFFFF
`define FPC_ERASED_WORD 32'hFFFFFFFF
// ==========================================
// interrupt status bit positions
`define FPC_INT_ACCESS 0
`define FPC_INT_PROG 1
// ==========================================
// operation times in microseconds
`define FPC_PROG_TIME_US 16'h0014
`define FPC_ERASE_TIME_US 16'h000A
`endif

// *** logic/fpc_flash_protection_controller.v ***
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.vh"
module fpc_flash_protection_controller #(
	parameter ADDR_W = 15,
	parameter PAGE_W = 8,
	parameter PROT_W = 9,
	parameter [15:0] PROG_US = `FPC_PROG_TIME_US,
	parameter [15:0] ERASE_US = `FPC_ERASE_TIME_US
) (
	input wire mclk_in,
	input wire reset_in,
	input wire nv_factory_reset_in,
	input wire rd_req_in,
	input wire rd_fetch_in,
	input wire [ADDR_W-1:0] rd_addr_in,
	output wire rd_ready_out,
	output reg rd_valid_out,
	output reg rd_fault_out,
	output reg [31:0] rd_data_out,
	input wire [ADDR_W-1:0] flash_target_address_in,
	input wire [31:0] flash_write_data_in,
	input wire ctrl_write_in,
	input wire [31:0] ctrl_wdata_in,
	output wire [31:0] flash_operation_control_out,
	input wire usec_write_in,
	input wire [7:0] usec_wdata_in,
	output wire [7:0] microsecond_reload_out,
	input wire prot_write_in,
	input wire [1:0] prot_select_in,
	input wire [31:0] prot_wdata_in,
	output wire [63:0] block_program_enable_bits_out,
	output wire [63:0] block_read_enable_bits_out,
	input wire mask_write_in,
	input wire [1:0] mask_wdata_in,
	output wire [1:0] flash_interrupt_mask_reg_out,
	input wire clear_write_in,
	input wire [1:0] flash_interrupt_status_clear_in,
	output wire [1:0] flash_raw_interrupt_status_out,
	output wire [1:0] flash_masked_interrupt_status_out,
	output wire flash_irq_out
);
	localparam S_IDLE = 3'h0;
	localparam S_WAIT = 3'h1;
	localparam S_APPLY = 3'h2;
	localparam S_DONE = 3'h3;
	localparam S_COMMIT = 3'h4;
	localparam K_WRITE = 2'h0;
	localparam K_ERASE = 2'h1;
	localparam K_MASS_ERASE_BIT = 2'h2;
	localparam K_COMMIT = 2'h3;
	localparam [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};
	localparam [ADDR_W-1:0] PAGE_MASK = {{(ADDR_W-PAGE_W){1'b0}}, {PAGE_W{1'b1}}};

	// ==========================================
	// storage
	// nonvolatile array, never reset
	reg [31:0] mem_reg [0:(1<<ADDR_W)-1];
	reg [31:0] read0_reg, prog0_reg, read1_reg, prog1_reg;
	reg [31:0] read0_nv_reg, prog0_nv_reg, read1_nv_reg, prog1_nv_reg;
	reg [7:0] usec_reload_reg;
	reg [7:0] usec_cnt_reg;
	reg [2:0] state_reg, state_next;
	reg [1:0] kind_reg, kind_next;
	reg [3:0] op_bits_reg, op_bits_next;
	reg [15:0] dur_reg, dur_next;
	reg [ADDR_W-1:0] addr_reg, addr_next;
	reg [ADDR_W-1:0] idx_reg, idx_next;
	reg [31:0] data_reg, data_next;
	reg skipped_reg, skipped_next;
	reg [1:0] raw_reg;
	reg [1:0] mask_reg;
	reg mem_we;
	reg [ADDR_W-1:0] mem_waddr;
	reg [31:0] mem_wdata;
	reg set_access, set_prog, commit_now;

	wire [63:0] prog_eff;
	wire [63:0] read_eff;
	wire tick;
	wire key_ok;
	wire [1:0] set_vec;

	// ==========================================
	// protection lookup per 2-KB block
	function prot_bit;
		input [63:0] bits;
		input [ADDR_W-1:0] a;
		begin
			prot_bit = bits[a[ADDR_W-1:PROT_W]];
		end
	endfunction

	// working copy ANDed with committed copy
	assign prog_eff = {prog1_reg & prog1_nv_reg, prog0_reg & prog0_nv_reg};
	assign read_eff = {read1_reg & read1_nv_reg, read0_reg & read0_nv_reg};
	assign block_program_enable_bits_out = prog_eff;
	assign block_read_enable_bits_out = read_eff;

	// ==========================================
	// microsecond tick
	// tick every reload plus one cycles
	assign tick = (usec_cnt_reg == 8'h00);
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			usec_reload_reg <= `FPC_USEC_RESET;
			usec_cnt_reg <= `FPC_USEC_RESET;
		end else begin
			if (usec_write_in)
				usec_reload_reg <= usec_wdata_in;
			if (tick)
				usec_cnt_reg <= usec_reload_reg;
			else
				usec_cnt_reg <= usec_cnt_reg - 8'h01;
		end
	end
	assign microsecond_reload_out = usec_reload_reg;

	// ==========================================
	// protection registers
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			read0_reg <= `FPC_PROT_RESET;
			prog0_reg <= `FPC_PROT_RESET;
			read1_reg <= `FPC_PROT_RESET;
			prog1_reg <= `FPC_PROT_RESET;
		end else if (prot_write_in) begin
			case (prot_select_in)
			`FPC_SEL_READ0: read0_reg <= read0_reg & prot_wdata_in;
			`FPC_SEL_PROG0: prog0_reg <= prog0_reg & prot_wdata_in;
			`FPC_SEL_READ1: read1_reg <= read1_reg & prot_wdata_in;
			default: prog1_reg <= prog1_reg & prot_wdata_in;
			endcase
		end
	end

	// committed copies survive reset_in, only factory restore opens them
	always @(posedge mclk_in or posedge nv_factory_reset_in) begin
		if (nv_factory_reset_in) begin
			read0_nv_reg <= `FPC_PROT_RESET;
			prog0_nv_reg <= `FPC_PROT_RESET;
			read1_nv_reg <= `FPC_PROT_RESET;
			prog1_nv_reg <= `FPC_PROT_RESET;
		end else if (commit_now) begin
			case (addr_reg[1:0])
			`FPC_SEL_READ0: read0_nv_reg <= read0_nv_reg & read0_reg;
			`FPC_SEL_PROG0: prog0_nv_reg <= prog0_nv_reg & prog0_reg;
			`FPC_SEL_READ1: read1_nv_reg <= read1_nv_reg & read1_reg;
			default: prog1_nv_reg <= prog1_nv_reg & prog1_reg;
			endcase
		end
	end

	// ==========================================
	// operation sequencer
	assign key_ok = (ctrl_wdata_in[`FPC_KEY_HI:`FPC_KEY_LO] == `FPC_KEY);
	always @* begin
		state_next = state_reg;
		kind_next = kind_reg;
		op_bits_next = op_bits_reg;
		dur_next = dur_reg;
		addr_next = addr_reg;
		idx_next = idx_reg;
		data_next = data_reg;
		skipped_next = skipped_reg;
		mem_we = 1'b0;
		mem_waddr = idx_reg;
		mem_wdata = `FPC_ERASED_WORD;
		set_access = 1'b0;
		set_prog = 1'b0;
		commit_now = 1'b0;
		case (state_reg)
		S_IDLE: begin
			// key plus one operation bit; new requests ignored while busy
			if (ctrl_write_in && key_ok) begin
				addr_next = flash_target_address_in;
				data_next = flash_write_data_in;
				skipped_next = 1'b0;
				if (ctrl_wdata_in[`FPC_OP_WRITE] ||
						ctrl_wdata_in[`FPC_OP_ERASE]) begin
					if (!prot_bit(prog_eff, flash_target_address_in)) begin
						set_access = 1'b1;
					end else begin
						if (ctrl_wdata_in[`FPC_OP_WRITE]) begin
							kind_next = K_WRITE;
							dur_next = PROG_US;
							op_bits_next = 4'h1;
						end else begin
							kind_next = K_ERASE;
							dur_next = ERASE_US;
							op_bits_next = 4'h2;
						end
						state_next = S_WAIT;
					end
				end else if (ctrl_wdata_in[`FPC_OP_MASS_ERASE_BIT]) begin
					kind_next = K_MASS_ERASE_BIT;
					dur_next = ERASE_US;
					op_bits_next = 4'h4;
					state_next = S_WAIT;
				end else if (ctrl_wdata_in[`FPC_OP_COMMIT]) begin
					kind_next = K_COMMIT;
					op_bits_next = 4'h8;
					state_next = S_COMMIT;
				end
			end
		end
		S_WAIT: begin
			if (tick) begin
				if (dur_reg <= 16'h0001) begin
					state_next = S_APPLY;
					if (kind_reg == K_MASS_ERASE_BIT)
						idx_next = {ADDR_W{1'b0}};
					else
						idx_next = addr_reg & ~PAGE_MASK;
				end else begin
					dur_next = dur_reg - 16'h0001;
				end
			end
		end
		S_APPLY: begin
			if (kind_reg == K_WRITE) begin
				mem_we = 1'b1;
				mem_waddr = addr_reg;
				mem_wdata = mem_reg[addr_reg] & data_reg;
				state_next = S_DONE;
			end else begin
				// erase one word per cycle to all ones
				mem_we = prot_bit(prog_eff, idx_reg);
				if (!prot_bit(prog_eff, idx_reg))
					skipped_next = 1'b1;
				idx_next = idx_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
				if ((kind_reg == K_ERASE &&
						(idx_reg & PAGE_MASK) == PAGE_MASK) ||
						idx_reg == LAST_ADDR)
					state_next = S_DONE;
			end
		end
		S_DONE: begin
			set_prog = 1'b1;
			// blocks left untouched by mass erase
			set_access = skipped_reg;
			op_bits_next = 4'h0;
			state_next = S_IDLE;
		end
		S_COMMIT: begin
			commit_now = 1'b1;
			op_bits_next = 4'h0;
			state_next = S_IDLE;
		end
		default: begin
			op_bits_next = 4'h0;
			state_next = S_IDLE;
		end
		endcase
	end

	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= S_IDLE;
			kind_reg <= K_WRITE;
			op_bits_reg <= 4'h0;
			dur_reg <= 16'h0000;
			addr_reg <= {ADDR_W{1'b0}};
			idx_reg <= {ADDR_W{1'b0}};
			data_reg <= 32'h00000000;
			skipped_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			op_bits_reg <= op_bits_next;
			dur_reg <= dur_next;
			addr_reg <= addr_next;
			idx_reg <= idx_next;
			data_reg <= data_next;
			skipped_reg <= skipped_next;
		end
	end
	assign flash_operation_control_out = {28'h0000000, op_bits_reg};

	always @(posedge mclk_in) begin
		if (mem_we)
			mem_reg[mem_waddr] <= mem_wdata;
	end

	// ==========================================
	// core read port
	// stall reads and fetches while busy
	assign rd_ready_out = (state_reg == S_IDLE);
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_valid_out <= 1'b0;
			rd_fault_out <= 1'b0;
			rd_data_out <= 32'h00000000;
		end else begin
			rd_valid_out <= rd_req_in && rd_ready_out;
			rd_fault_out <= 1'b0;
			if (rd_req_in && rd_ready_out) begin
				if (!rd_fetch_in && !prot_bit(read_eff, rd_addr_in)) begin
					rd_fault_out <= 1'b1;
					rd_data_out <= 32'h00000000;
				end else begin
					rd_data_out <= mem_reg[rd_addr_in];
				end
			end
		end
	end

	// ==========================================
	// interrupt status
	assign set_vec = {set_prog, set_access};
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			raw_reg <= 2'h0;
			mask_reg <= 2'h0;
		end else begin
			if (mask_write_in)
				mask_reg <= mask_wdata_in;
			// write one clears, a same-cycle event wins
			if (clear_write_in)
				raw_reg <= (raw_reg & ~flash_interrupt_status_clear_in) | set_vec;
			else
				raw_reg <= raw_reg | set_vec;
		end
	end
	// raw flags visible regardless of mask
	assign flash_raw_interrupt_status_out = raw_reg;
	assign flash_interrupt_mask_reg_out = mask_reg;
	assign flash_masked_interrupt_status_out = raw_reg & mask_reg;
	assign flash_irq_out = |(raw_reg & mask_reg);
endmodule
`default_nettype wire

// *** test/fpc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module fpc_props (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic nv_factory_reset_in,
	input wire logic rd_req_in,
	input wire logic rd_fetch_in,
	input wire logic rd_ready_out,
	input wire logic rd_valid_out,
	input wire logic rd_fault_out,
	input wire logic [31:0] rd_data_out,
	input wire logic [31:0] flash_operation_control_out,
	input wire logic usec_write_in,
	input wire logic [7:0] usec_wdata_in,
	input wire logic [7:0] microsecond_reload_out,
	input wire logic [63:0] block_program_enable_bits_out,
	input wire logic [1:0] flash_interrupt_mask_reg_out,
	input wire logic [1:0] flash_raw_interrupt_status_out,
	input wire logic [1:0] flash_masked_interrupt_status_out,
	input wire logic flash_irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_masked_and: assert property (
		flash_masked_interrupt_status_out == (flash_raw_interrupt_status_out
		& flash_interrupt_mask_reg_out)) else $error("masked status wrong");
	a_irq_or: assert property (
		flash_irq_out == |flash_masked_interrupt_status_out)
		else $error("irq wrong");
	a_busy_stall: assert property (
		|flash_operation_control_out[3:0] |-> !rd_ready_out)
		else $error("read taken while busy");
	a_fetch_answer: assert property (
		rd_req_in && rd_ready_out && rd_fetch_in |=> rd_valid_out
		&& !rd_fault_out) else $error("fetch not answered");
	a_no_stray: assert property (
		!(rd_req_in && rd_ready_out) |=> !rd_valid_out)
		else $error("valid without request");
	a_fault_zero: assert property (
		rd_fault_out |-> rd_valid_out && rd_data_out == 32'h0)
		else $error("fault without zero data");
	a_prot_no_rise: assert property (
		disable iff (reset_in || nv_factory_reset_in)
		(block_program_enable_bits_out
		& ~$past(block_program_enable_bits_out)) == 64'h0)
		else $error("protection bit rose");
	a_reload_load: assert property (
		usec_write_in |=> microsecond_reload_out == $past(usec_wdata_in))
		else $error("reload not loaded");
	a_done_flag: assert property (
		$fell(flash_operation_control_out[0])
		|| $fell(flash_operation_control_out[1])
		|| $fell(flash_operation_control_out[2])
		|-> flash_raw_interrupt_status_out[1]) else $error("no done flag");
	c_fault: cover property (rd_fault_out);
	c_erase: cover property ($fell(flash_operation_control_out[1]));
	c_irq: cover property (flash_irq_out);
	c_mass: cover property ($fell(flash_operation_control_out[2]));
endmodule
bind fpc_flash_protection_controller fpc_props u_props (.mclk_in,
	.reset_in, .nv_factory_reset_in, .rd_req_in, .rd_fetch_in,
	.rd_ready_out, .rd_valid_out, .rd_fault_out, .rd_data_out,
	.flash_operation_control_out, .usec_write_in, .usec_wdata_in,
	.microsecond_reload_out, .block_program_enable_bits_out,
	.flash_interrupt_mask_reg_out, .flash_raw_interrupt_status_out,
	.flash_masked_interrupt_status_out, .flash_irq_out);
`default_nettype wire

// *** test/fpc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// core side read requester
module fpc_core_model (
	input wire logic clk_in,
	input wire logic ready_in,
	input wire logic valid_in,
	input wire logic fault_in,
	input wire logic [31:0] data_in,
	output logic req_out,
	output logic fetch_out,
	output logic [14:0] addr_out
);
	initial begin
		req_out = 1'b0;
		fetch_out = 1'b0;
		addr_out = 15'h0;
	end
	task automatic rd(input logic f, input logic [14:0] a,
		output logic [33:0] r);
		int i;
		req_out <= 1'b1;
		fetch_out <= f;
		addr_out <= a;
		i = 0;
		@(negedge clk_in);
		while (ready_in !== 1'b1 && i < 4000) begin
			i++;
			@(negedge clk_in);
		end
		if (i >= 4000) begin
			testbench.fails++;
			testbench.finish_test();
		end
		@(posedge clk_in);
		// released lines show the inverse, not a stale copy
		req_out <= 1'b0;
		fetch_out <= ~f;
		addr_out <= ~a;
		@(negedge clk_in);
		r = {valid_in, fault_in, data_in};
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// factory-fresh part: committed copies start open
	logic mclk_in = 0, reset_in = 1, nv_factory_reset_in = 1;
	logic rd_req_in, rd_fetch_in, rd_ready_out, rd_valid_out, rd_fault_out;
	logic [14:0] rd_addr_in, flash_target_address_in = 0;
	logic [31:0] rd_data_out, flash_write_data_in = 0, ctrl_wdata_in = 0;
	logic [31:0] flash_operation_control_out, prot_wdata_in = 0;
	logic [7:0] usec_wdata_in = 0, microsecond_reload_out;
	logic [1:0] prot_select_in = 0, mask_wdata_in = 0;
	logic [1:0] flash_interrupt_status_clear_in = 0;
	logic [63:0] block_program_enable_bits_out, block_read_enable_bits_out;
	logic [1:0] flash_interrupt_mask_reg_out, flash_raw_interrupt_status_out;
	logic [1:0] flash_masked_interrupt_status_out;
	logic flash_irq_out, ctrl_write_in = 0;
	logic [3:0] st = 0;
	logic [3:0] op_seen;
	logic [33:0] r;
	int fails = 0, n_compared = 0;
	wire usec_write_in = st[0], prot_write_in = st[1];
	wire mask_write_in = st[2], clear_write_in = st[3];
	fpc_flash_protection_controller #(.PROG_US(16'h0001),
		.ERASE_US(16'h0001)) uut (.mclk_in, .reset_in,
		.nv_factory_reset_in, .rd_req_in, .rd_fetch_in, .rd_addr_in,
		.rd_ready_out, .rd_valid_out, .rd_fault_out, .rd_data_out,
		.flash_target_address_in, .flash_write_data_in, .ctrl_write_in,
		.ctrl_wdata_in, .flash_operation_control_out, .usec_write_in,
		.usec_wdata_in, .microsecond_reload_out, .prot_write_in,
		.prot_select_in, .prot_wdata_in, .block_program_enable_bits_out,
		.block_read_enable_bits_out, .mask_write_in, .mask_wdata_in,
		.flash_interrupt_mask_reg_out, .clear_write_in,
		.flash_interrupt_status_clear_in, .flash_raw_interrupt_status_out,
		.flash_masked_interrupt_status_out, .flash_irq_out);
	fpc_core_model core (.clk_in(mclk_in), .ready_in(rd_ready_out),
		.valid_in(rd_valid_out), .fault_in(rd_fault_out),
		.data_in(rd_data_out), .req_out(rd_req_in),
		.fetch_out(rd_fetch_in), .addr_out(rd_addr_in));
	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic finish_test();
		$display("compared=%0d fails=%0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one control word, then wait until its bit drops
	task automatic ctl(input logic [31:0] w, input logic [14:0] a,
		input logic [31:0] d);
		int i;
		ctrl_write_in <= 1'b1;
		ctrl_wdata_in <= w;
		flash_target_address_in <= a;
		flash_write_data_in <= d;
		@(posedge mclk_in);
		ctrl_write_in <= 1'b0;
		i = 0;
		@(negedge mclk_in);
		op_seen = flash_operation_control_out[3:0];
		while (flash_operation_control_out[3:0] !== 4'h0 && i < 40000) begin
			i++;
			@(negedge mclk_in);
		end
		if (i >= 40000) begin
			fails++;
			finish_test();
		end
		@(posedge mclk_in);
	endtask
	// k: 0 reload, 1 protection, 2 mask, 3 clear
	task automatic cfg(input logic [1:0] k, input logic [31:0] v,
		input logic [1:0] s);
		st <= 4'h1 << k;
		usec_wdata_in <= v[7:0];
		prot_wdata_in <= v;
		mask_wdata_in <= v[1:0];
		flash_interrupt_status_clear_in <= v[1:0];
		prot_select_in <= s;
		@(posedge mclk_in);
		st <= 4'h0;
		@(posedge mclk_in);
	endtask
	initial begin
		repeat (16) @(posedge mclk_in);
		reset_in <= 1'b0;
		nv_factory_reset_in <= 1'b0;
		@(posedge mclk_in);
		cmp(microsecond_reload_out, 64'h31);
		cmp(block_read_enable_bits_out, ~64'h0);
		cfg(0, 32'h27, 0);
		cmp(microsecond_reload_out, 64'h27);
		ctl(32'hA4420002, 15'h0, 0);
		cmp(flash_raw_interrupt_status_out, 64'h2);
		cmp(flash_irq_out, 64'h0);
		core.rd(0, 15'h0FF, r);
		cmp(r, {2'b10, 32'hFFFFFFFF});
		ctl(32'hA4420001, 15'h0, 32'h12345678);
		cmp(op_seen, 64'h1);
		ctl(32'hA4420001, 15'h0, 32'hFFFF0000);
		ctl(32'hA5420002, 15'h0, 0);
		cmp(op_seen, 64'h0);
		core.rd(0, 15'h0, r);
		cmp(r, {2'b10, 32'h12340000});
		cfg(2, 32'h3, 0);
		cmp(flash_interrupt_mask_reg_out, 64'h3);
		cmp(flash_irq_out, 64'h1);
		cfg(3, 32'h1, 0);
		cmp(flash_raw_interrupt_status_out, 64'h2);
		cfg(3, 32'h2, 0);
		cmp(flash_masked_interrupt_status_out, 64'h0);
		cfg(1, 32'hFFFFFFFE, 0);
		cmp(block_read_enable_bits_out, ~64'h1);
		core.rd(0, 15'h1FF, r);
		cmp(r, {2'b11, 32'h0});
		ctl(32'hA4420001, 15'h0, 32'h0000FFFF);
		core.rd(1, 15'h0, r);
		cmp(r, {2'b10, 32'h0});
		cfg(3, 32'h3, 0);
		cfg(1, 32'hFFFFFFFE, 1);
		ctl(32'hA4420002, 15'h0, 0);
		cmp(op_seen, 64'h0);
		cmp(flash_raw_interrupt_status_out, 64'h1);
		cmp(flash_irq_out, 64'h1);
		core.rd(1, 15'h0, r);
		cmp(r, {2'b10, 32'h0});
		cfg(3, 32'h3, 0);
		ctl(32'hA4420004, 15'h0, 0);
		cmp(op_seen, 64'h4);
		cmp(flash_raw_interrupt_status_out, 64'h3);
		core.rd(1, 15'h0, r);
		cmp(r, {2'b10, 32'h0});
		core.rd(0, 15'h200, r);
		cmp(r, {2'b10, 32'hFFFFFFFF});
		ctl(32'hA4420008, 15'h1, 0);
		cmp(op_seen, 64'h8);
		reset_in <= 1'b1;
		@(posedge mclk_in);
		reset_in <= 1'b0;
		@(posedge mclk_in);
		cmp(block_program_enable_bits_out, ~64'h1);
		cmp(block_read_enable_bits_out, ~64'h0);
		finish_test();
	end
endmodule
`default_nettype wire
